//--- pacing_consts.svh
/*
  Timing counts, limits and widths for the converter pacing block.
  Assumes core_clk at 125 MHz and a 5 MHz internal timebase derived from it.
*/
`ifndef PACING_CONSTS_SVH
`define PACING_CONSTS_SVH

`define CLK_PERIOD_NS        8
`define TIMEBASE_HZ          5000000
`define CLK_HZ               125000000
`define TB_DIV               (`CLK_HZ / `TIMEBASE_HZ)
`define TB_DIV_M1            5'h18
`define START_LAT_NS         400
`define START_LAT_CYC        (`START_LAT_NS / `CLK_PERIOD_NS)
`define ENABLE_LAT_NS        1000
`define ENABLE_LAT_CYC       (`ENABLE_LAT_NS / `CLK_PERIOD_NS)
`define BURST_STEP_NS        1000
`define BURST_STEP_CYC       (`BURST_STEP_NS / `CLK_PERIOD_NS)
`define BURST_STEP_M1        7'h7C
`define BURST_MIN_US         6'h03
`define BURST_MAX_US         7'h40
`define PACER_DIV_MIN        32'h0000_000F
`define QUEUE_LEN_W          8
`define SAMPLE_CNT_W         32

`endif

//--- pacing_pkg.sv
/*
  Types for the converter pacing block.
  Assumes pacing_consts.svh is on the include path.
*/
package pacing_pkg;

  typedef enum logic [1:0] {
    PACER_SOFTWARE = 2'h0,
    PACER_INTERNAL = 2'h1,
    PACER_EXTERNAL = 2'h2
  } pacer_src_t;

  typedef enum logic [1:0] {
    START_INTERNAL = 2'h0,
    START_DIGITAL  = 2'h1
  } start_src_t;

  typedef enum logic [1:0] {
    STOP_NONE      = 2'h0,
    STOP_ABOUT     = 2'h1,
    STOP_PRE       = 2'h2
  } stop_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_WAIT    = 4'b0010,
    ST_RUN     = 4'b0100,
    ST_DONE    = 4'b1000
  } acq_state_t;

  typedef struct packed {
    logic                      burst_mode;
    pacer_src_t                pacer_src;
    logic                      ext_clk_falling;
    start_src_t                start_src;
    logic                      trig_falling;
    stop_mode_t                stop_mode;
    logic                      gate_enable;
    logic                      gate_active_low;
    logic [31:0]               pacer_divisor;
    logic [6:0]                burst_period_us;
    logic [7:0]                queue_last;
    logic [31:0]               post_count;
  } acq_cfg_t;

endpackage : pacing_pkg

//--- tick_divider.sv
/*
  Programmable down-counter producing one-cycle ticks.
  Assumes load is a one-cycle restart; divisor of zero is treated as one.
*/
module tick_divider (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        run,
  input  wire logic        step,
  input  wire logic        load,
  input  wire logic [31:0] divisor,
  output logic             tick
);
  logic [31:0] count_reg;
  logic [31:0] count_next;
  wire         expire = run && step && (count_reg <= 32'h0000_0001);

  assign count_next = load   ? divisor :
                      expire ? divisor :
                      (run && step) ? count_reg - 32'h0000_0001 : count_reg;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      count_reg <= 32'h0000_0000;
      tick      <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick      <= expire && !load;
    end
  end
endmodule : tick_divider

//--- adc_pacing_trigger_control.sv
/*
  Converter pacing, burst and trigger sequencing over a channel queue.
  Assumes static configuration while enabled and asynchronous pins from outside.
*/
// Notes on behaviour
// - Paced and burst modes; paced by default.
// - Paced: one conversion per pacer tick, next channel.
// - Burst: each pacer tick scans whole queue.
// - Burst conversions spaced by burst clock period.
// - Internal pacer counts 5 MHz timebase.
// - Software pacer converts only on host command.
// - External pace clock edge polarity is selectable.
// - Burst period 3 to 64 us, 1 us steps.
// - Internal start begins on software enable.
// - Digital trigger edge polarity is selectable.
// - Internal clock idle until trigger, then aligned.
// - External clock: trigger arms, next edge converts.
// - Onboard clock starts within 1 us of enable.
// - About trigger stops after programmed sample count.
// - Pre-trigger sampling ends on digital trigger.
// - Gate inactive halts internal and external pacer, not software pacer; reloads on activation.
`include "pacing_consts.svh"
module adc_pacing_trigger_control
  import pacing_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire acq_cfg_t    cfg,
  input  wire logic        acq_enable,
  input  wire logic        sw_convert,
  input  wire logic        simultaneous_sample_hold_mode,
  input  wire logic        external_pace_clock_in,
  input  wire logic        trigger_gate_in,
  output logic             convert_start,
  output logic [7:0]       channel_index,
  output logic             acq_running,
  output logic             acq_done
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] xclk_sync_reg;
  logic [1:0] trig_sync_reg;
  logic       xclk_prev_reg;
  logic       trig_prev_reg;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      xclk_sync_reg <= 2'h0;
      trig_sync_reg <= 2'h0;
      xclk_prev_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
    end else begin
      xclk_sync_reg <= {xclk_sync_reg[0], external_pace_clock_in};
      trig_sync_reg <= {trig_sync_reg[0], trigger_gate_in};
      xclk_prev_reg <= xclk_sync_reg[1];
      trig_prev_reg <= trig_sync_reg[1];
    end
  end

  function automatic logic edge_of(input logic now, input logic prev, input logic falling);
    edge_of = falling ? (prev && !now) : (!prev && now);
  endfunction : edge_of

  wire xclk_edge = edge_of(xclk_sync_reg[1], xclk_prev_reg, cfg.ext_clk_falling);
  wire trig_edge = edge_of(trig_sync_reg[1], trig_prev_reg, cfg.trig_falling);
  // Gate shares the trigger pin; level taken after synchronising
  wire gate_open = !cfg.gate_enable || (trig_sync_reg[1] ^ cfg.gate_active_low);

  // ----------------------------------------------------------------
  // Timebase and acquisition state
  // ----------------------------------------------------------------
  acq_state_t state_reg;
  acq_state_t state_next;
  logic [4:0] tb_cnt_reg;
  logic       gate_prev_reg;
  logic       about_seen_reg;
  logic [31:0] post_cnt_reg;

  wire tb_step   = (tb_cnt_reg == `TB_DIV_M1);
  wire running   = (state_reg == ST_RUN);
  wire use_trig  = (cfg.start_src == START_DIGITAL);
  wire gate_rise = gate_open && !gate_prev_reg;
  // Digital trigger starts the run; with internal start and a stop mode it is the stop event instead
  wire start_evt = use_trig ? trig_edge : 1'b1;
  wire stop_trig = running && trig_edge && (cfg.stop_mode != STOP_NONE) && !use_trig;
  wire start_go  = (state_reg == ST_WAIT) && start_evt;
  wire pacer_load = start_go || (cfg.gate_enable && gate_rise);

  logic pacer_tick;
  tick_divider u_pacer (
    .core_clk (core_clk),
    .resetn   (resetn),
    .run      (running && gate_open && (cfg.pacer_src == PACER_INTERNAL)),
    .step     (tb_step),
    .load     (pacer_load),
    .divisor  (cfg.pacer_divisor),
    .tick     (pacer_tick)
  );

  // ----------------------------------------------------------------
  // Pacer source select
  // ----------------------------------------------------------------
  // First internal conversion follows the trigger directly, well inside 400 ns
  logic first_reg;
  wire pace_evt = !running ? 1'b0 :
                  (cfg.pacer_src == PACER_SOFTWARE) ? sw_convert :
                  (cfg.pacer_src == PACER_INTERNAL) ? (first_reg || pacer_tick) :
                  (xclk_edge && gate_open);

  // ----------------------------------------------------------------
  // Burst sequencer
  // ----------------------------------------------------------------
  logic        burst_active_reg;
  logic [6:0]  burst_cyc_reg;
  logic [6:0]  burst_us_reg;
  logic [7:0]  burst_left_reg;
  logic [6:0]  burst_period;
  // Clamp to the legal range so a bad setting cannot outrun the converter
  assign burst_period = (cfg.burst_period_us < 7'(`BURST_MIN_US)) ? 7'(`BURST_MIN_US) :
                        (cfg.burst_period_us > `BURST_MAX_US) ? `BURST_MAX_US :
                        cfg.burst_period_us;
  wire us_step    = (burst_cyc_reg == `BURST_STEP_M1);
  wire burst_slot = burst_active_reg && us_step && (burst_us_reg == burst_period - 7'h01);
  // Hold accessory spends one extra slot per scan
  wire [7:0] scan_len = cfg.queue_last + (simultaneous_sample_hold_mode ? 8'h01 : 8'h00);
  wire burst_begin = cfg.burst_mode && pace_evt && !burst_active_reg;
  wire conv_now = cfg.burst_mode ? (burst_begin || burst_slot) : pace_evt;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      burst_active_reg <= 1'b0;
      burst_cyc_reg    <= 7'h00;
      burst_us_reg     <= 7'h00;
      burst_left_reg   <= 8'h00;
    end else if (burst_begin) begin
      burst_active_reg <= (scan_len != 8'h00);
      burst_cyc_reg    <= 7'h00;
      burst_us_reg     <= 7'h00;
      burst_left_reg   <= scan_len;
    end else if (burst_active_reg) begin
      burst_cyc_reg <= us_step ? 7'h00 : burst_cyc_reg + 7'h01;
      if (burst_slot) begin
        burst_us_reg     <= 7'h00;
        burst_left_reg   <= burst_left_reg - 8'h01;
        burst_active_reg <= (burst_left_reg != 8'h01) && running;
      end else if (us_step) begin
        burst_us_reg <= burst_us_reg + 7'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel queue and stop counting
  // ----------------------------------------------------------------
  wire [7:0] chan_wrap = (channel_index >= cfg.queue_last) ? 8'h00 : channel_index + 8'h01;
  wire post_done = about_seen_reg && conv_now && (post_cnt_reg <= 32'h0000_0001);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (acq_enable) state_next = ST_WAIT;
      ST_WAIT: if (!acq_enable) state_next = ST_IDLE;
               else if (start_evt) state_next = ST_RUN;
      ST_RUN: begin
        if (!acq_enable) state_next = ST_IDLE;
        else if (stop_trig && cfg.stop_mode == STOP_PRE) state_next = ST_DONE;
        else if (post_done && cfg.stop_mode == STOP_ABOUT) state_next = ST_DONE;
      end
      ST_DONE: if (!acq_enable) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_reg      <= ST_IDLE;
      tb_cnt_reg     <= 5'h00;
      gate_prev_reg  <= 1'b0;
      first_reg      <= 1'b0;
      about_seen_reg <= 1'b0;
      post_cnt_reg   <= 32'h0000_0000;
      convert_start  <= 1'b0;
      channel_index  <= 8'h00;
      acq_running    <= 1'b0;
      acq_done       <= 1'b0;
    end else begin
      state_reg     <= state_next;
      // Timebase restarts with the run so the first tick is aligned
      tb_cnt_reg    <= (start_go || tb_step) ? 5'h00 : tb_cnt_reg + 5'h01;
      gate_prev_reg <= gate_open;
      first_reg     <= start_go && (cfg.pacer_src == PACER_INTERNAL);
      convert_start <= conv_now && running;
      if (state_reg != ST_RUN) begin
        channel_index <= 8'h00;
      end else if (conv_now) begin
        channel_index <= chan_wrap;
      end
      if (stop_trig && cfg.stop_mode == STOP_ABOUT && !about_seen_reg) begin
        about_seen_reg <= 1'b1;
        post_cnt_reg   <= cfg.post_count;
      end else if (state_reg != ST_RUN) begin
        about_seen_reg <= 1'b0;
      end else if (about_seen_reg && conv_now) begin
        post_cnt_reg <= post_cnt_reg - 32'h0000_0001;
      end
      acq_running <= (state_next == ST_RUN);
      acq_done    <= (state_next == ST_DONE);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_paced_one_conv: assert property (@(posedge core_clk) disable iff (!resetn)
    (!cfg.burst_mode && pace_evt) |=> convert_start)
    else $error("paced tick gave no conversion");
  a_chan_wrap_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    (running && conv_now && channel_index >= cfg.queue_last) |=> channel_index == 8'h00)
    else $error("queue did not wrap");
  a_sw_only_conv: assert property (@(posedge core_clk) disable iff (!resetn)
    (!cfg.burst_mode && cfg.pacer_src == PACER_SOFTWARE && running && !sw_convert) |=> !convert_start)
    else $error("conversion without software command");
  a_first_conv_fast: assert property (@(posedge core_clk) disable iff (!resetn)
    (start_go && cfg.pacer_src == PACER_INTERNAL && !cfg.burst_mode && acq_enable) |-> ##[1:3] convert_start)
    else $error("first conversion late");
  // Enable seen in idle, then still held one cycle later
  sequence s_internal_enable;
    (state_reg == ST_IDLE && acq_enable && !use_trig) ##1 acq_enable;
  endsequence

  a_internal_start: assert property (@(posedge core_clk) disable iff (!resetn)
    s_internal_enable |=> state_reg == ST_RUN)
    else $error("internal start did not run");
  a_pre_stop: assert property (@(posedge core_clk) disable iff (!resetn)
    (stop_trig && cfg.stop_mode == STOP_PRE && acq_enable) |=> state_reg == ST_DONE)
    else $error("pre-trigger did not stop");
  a_ext_armed_only: assert property (@(posedge core_clk) disable iff (!resetn)
    (!cfg.burst_mode && cfg.pacer_src == PACER_EXTERNAL && !xclk_edge) |=> !convert_start)
    else $error("external conversion without edge");
  a_burst_spacing: assert property (@(posedge core_clk) disable iff (!resetn)
    burst_slot |=> !burst_slot [*8])
    else $error("burst slots too close");
  a_gate_halts: assert property (@(posedge core_clk) disable iff (!resetn)
    (cfg.pacer_src == PACER_INTERNAL && !gate_open && running && !first_reg && !cfg.burst_mode) |=> !convert_start)
    else $error("conversion while gate closed");
endmodule : adc_pacing_trigger_control

//--- pace_trig_source.sv
/*
  Far-side model: external pace clock and trigger pin source.
  Assumes the bench calls drive() from its main sequence only.
*/
module pace_trig_source (
  input  wire logic core_clk,
  output logic      external_pace_clock_in,
  output logic      trigger_gate_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Pin driver
  // ----------------------------------------
  initial begin
    external_pace_clock_in = 1'b0;
    trigger_gate_in        = 1'b0;
  end

  // Levels change just after an edge, then hold; pace edges never closer than 3 us
  task automatic drive(input logic pace, input logic trig, input int hold);
    int n;
    n = hold;
    if (pace !== external_pace_clock_in && n < 375) n = 375;
    @(posedge core_clk);
    external_pace_clock_in <= pace;
    trigger_gate_in        <= trig;
    repeat (n) @(posedge core_clk);
  endtask : drive
endmodule : pace_trig_source

//--- tb_top.sv
/*
  Self-checking bench for the converter pacing block.
  Assumes pacing_pkg and pace_trig_source are compiled first.
*/
module tb_top import pacing_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Signals, clock, monitor
  // ----------------------------------------
  logic       core_clk = 1'b0;
  logic       resetn;
  logic       acq_enable;
  logic       sw_convert;
  logic       hold_mode;
  acq_cfg_t   cfg;
  wire logic  pace_pin;
  wire logic  trig_pin;
  wire logic  convert_start;
  wire logic [7:0] channel_index;
  wire logic  acq_running;
  wire logic  acq_done;
  int         fails;
  int         n_compared;
  int         n_conv;
  int         last_gap;
  time        last_at;

  always #4 core_clk = ~core_clk;

  // Pulses are one cycle and far apart, so a rising edge counts each one
  always @(posedge convert_start) begin
    n_conv++;
    last_gap = int'(($time - last_at) / 8);
    last_at = $time;
  end

  adc_pacing_trigger_control dut (
    .core_clk(core_clk), .resetn(resetn), .cfg(cfg), .acq_enable(acq_enable),
    .sw_convert(sw_convert), .simultaneous_sample_hold_mode(hold_mode),
    .external_pace_clock_in(pace_pin), .trigger_gate_in(trig_pin),
    .convert_start(convert_start), .channel_index(channel_index),
    .acq_running(acq_running), .acq_done(acq_done));

  pace_trig_source src (.core_clk(core_clk), .external_pace_clock_in(pace_pin), .trigger_gate_in(trig_pin));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  // Returns at the falling edge where a pulse is settled high
  task automatic wait_conv(input int lim);
    int k;
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (convert_start !== 1'b1 && k < lim);
    if (k >= lim) chk("pulse wait", 0, 1);
  endtask : wait_conv

  task automatic start(input acq_cfg_t c);
    @(posedge core_clk);
    cfg <= c;
    @(posedge core_clk);
    acq_enable <= 1'b1;
  endtask : start

  task automatic stop(input string name);
    @(posedge core_clk);
    acq_enable <= 1'b0;
    hold_mode  <= 1'b0;
    src.drive(1'b0, 1'b0, 20);
    $display("test %s done", name);
  endtask : stop

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_paced;
    acq_cfg_t c;
    c = '0;
    c.pacer_src = PACER_INTERNAL;
    c.pacer_divisor = 32'h0000_000F;
    c.queue_last = 8'h02;
    start(c);
    wait_conv(125);
    chk("first channel", channel_index, 8'h01);
    for (int k = 2; k <= 7; k++) begin
      wait_conv(400);
      chk("pace gap", last_gap, 375);
      chk("channel", channel_index, k % 3);
    end
    chk("running", acq_running, 1'b1);
    stop("paced");
  endtask : t_paced

  task automatic t_burst(input logic hold);
    acq_cfg_t c;
    int n0;
    c = '0;
    c.burst_mode = 1'b1;
    c.pacer_src = PACER_INTERNAL;
    c.pacer_divisor = 32'h0000_03E8;
    // Hold run also asks for a too-short period, expecting the clamp
    c.burst_period_us = hold ? 7'h01 : 7'h03;
    c.queue_last = 8'h03;
    @(posedge core_clk);
    hold_mode <= hold;
    n0 = n_conv;
    start(c);
    repeat (3000) @(posedge core_clk);
    chk("burst count", n_conv - n0, 4 + hold);
    chk("burst gap", last_gap, 375);
    if (!hold) chk("burst wrap", channel_index, 8'h00);
    stop("burst");
  endtask : t_burst

  // f selects the falling pace edge and the rising trigger edge
  task automatic t_ext(input logic f);
    acq_cfg_t c;
    int n0;
    c = '0;
    c.pacer_src = PACER_EXTERNAL;
    c.ext_clk_falling = f;
    c.start_src = START_DIGITAL;
    c.trig_falling = !f;
    src.drive(!f, !f, 20);
    n0 = n_conv;
    start(c);
    src.drive(f, !f, 375);
    src.drive(!f, !f, 375);
    chk("unarmed", n_conv - n0, 0);
    src.drive(!f, f, 20);
    for (int k = 1; k <= 2; k++) begin
      src.drive(f, f, 375);
      chk("idle edge", n_conv - n0, k - 1);
      src.drive(!f, f, 375);
      chk("active edge", n_conv - n0, k);
    end
    stop("external");
  endtask : t_ext

  task automatic t_sw;
    int n0;
    n0 = n_conv;
    start('0);
    repeat (200) @(posedge core_clk);
    chk("no host cmd", n_conv - n0, 0);
    for (int k = 0; k < 3; k++) begin
      @(posedge core_clk);
      sw_convert <= 1'b1;
      @(posedge core_clk);
      sw_convert <= 1'b0;
      repeat (20) @(posedge core_clk);
    end
    chk("host cmds", n_conv - n0, 3);
    stop("software");
  endtask : t_sw

  // Digital start with internal clock; the same pin then gates the pacer
  task automatic t_gate;
    acq_cfg_t c;
    int n0;
    time t0;
    c = '0;
    c.pacer_src = PACER_INTERNAL;
    c.pacer_divisor = 32'h0000_000F;
    c.start_src = START_DIGITAL;
    c.gate_enable = 1'b1;
    n0 = n_conv;
    start(c);
    repeat (100) @(posedge core_clk);
    chk("idle before trigger", n_conv - n0, 0);
    chk("armed not running", acq_running, 1'b0);
    src.drive(1'b0, 1'b1, 0);
    wait_conv(50);
    wait_conv(400);
    chk("aligned gap", last_gap, 375);
    // Close mid-period so a missing reload would show as an early pulse
    repeat (200) @(posedge core_clk);
    n0 = n_conv;
    src.drive(1'b0, 1'b0, 1000);
    chk("gate closed", n_conv - n0, 0);
    src.drive(1'b0, 1'b1, 0);
    t0 = $time;
    wait_conv(400);
    chk("gate reload", (last_at - t0 >= 355 * 8) && (last_at - t0 <= 379 * 8), 1'b1);
    stop("gate");
  endtask : t_gate

  task automatic t_stop(input stop_mode_t m, input string name);
    acq_cfg_t c;
    int n0;
    c = '0;
    c.pacer_src = PACER_INTERNAL;
    c.pacer_divisor = 32'h0000_000F;
    c.stop_mode = m;
    c.post_count = 32'h0000_0002;
    start(c);
    wait_conv(125);
    wait_conv(400);
    n0 = n_conv;
    src.drive(1'b0, 1'b1, 10);
    repeat (2000) @(posedge core_clk);
    chk("post samples", n_conv - n0, (m == STOP_ABOUT) ? 2 : 0);
    chk("done", acq_done, 1'b1);
    chk("stopped", acq_running, 1'b0);
    stop(name);
    chk("done cleared", acq_done, 1'b0);
  endtask : t_stop

  // ----------------------------------------
  // Main sequence, watchdog, verdict
  // ----------------------------------------
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  initial begin
    resetn = 1'b0;
    acq_enable = 1'b0;
    sw_convert = 1'b0;
    hold_mode = 1'b0;
    cfg = '0;
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    @(negedge core_clk);
    chk("reset outputs", {convert_start, acq_running, acq_done, channel_index}, 0);
    t_paced;
    t_burst(1'b0);
    t_burst(1'b1);
    t_ext(1'b1);
    t_ext(1'b0);
    t_sw;
    t_gate;
    t_stop(STOP_ABOUT, "about");
    t_stop(STOP_PRE, "pre");
    stop_test;
  end

  // Tests need about 21k cycles; this allows nearly four times that
  initial begin
    #640000;
    fails++;
    stop_test;
  end
endmodule : tb_top
